// >>> design/pcbp_core.sv
// Purpose: Back-end port of a 32-bit bus master/target core, with its bus sequencers.
// Assumes: core_clk is the bus clock; bus pins are synchronous to it, so no synchronisers.
// Notes:   Master address/data and target read data paths live elsewhere.
//
// Contract
// - Latency enable low ignores latency timer.
// - Strobe follows each clock where data moved.
// - Flag the last master data transfer.
// - Output copies of request and initiator ready.
// - Flag target abort of master transaction.
// - Flag timeout when no target responds.
// - Target address shown with address-valid strobe.
// - Target write data on the address output.
// - Command shown with address-valid strobe.
// - Byte enables shown during target data phases.
// - Address increment after each completed transfer.
// - Write-active held for whole target write.
module pcbp_core #(
   parameter logic [3:0] DEVSEL_TIMEOUT = pcbp_pkg::DEVSEL_LIMIT
) (
   input wire logic core_clk,
   input wire logic rst_b,
   // Master request side, driven by the DMA controller.
   input wire logic burst_req,
   input wire logic [3:0] pci_cmd,
   input wire logic latency_counter_enable,
   input wire logic [7:0] latency_timer,
   input wire logic last_transfer_left,
   output logic master_cmd_is_write,
   output logic transfer_delayed_strobe,
   output logic master_last_phase,
   output logic bus_request_copy_n,
   output logic initiator_ready_copy_n,
   output logic target_abort_flag,
   output logic target_timeout_flag,
   // Target side, read by the back-end decode logic.
   input wire logic user_select,
   output logic [31:0] target_addr_wdata,
   output logic [3:0] target_cmd_byte_en,
   output logic address_valid,
   output logic address_increment,
   output logic target_write_active,
   // Bus pins; each shared control pin is split into input, output and enable; AD is input only.
   input wire logic bus_gnt_n,
   output logic bus_req_n,
   input wire logic [31:0] bus_ad_in,
   input wire logic [3:0] bus_cbe_n_in,
   output logic [3:0] bus_cbe_n_out,
   output logic bus_cbe_oe,
   input wire logic bus_frame_n_in,
   output logic bus_frame_n_out,
   output logic bus_frame_oe,
   input wire logic bus_irdy_n_in,
   output logic bus_irdy_n_out,
   output logic bus_irdy_oe,
   input wire logic bus_trdy_n_in,
   output logic bus_trdy_n_out,
   input wire logic bus_devsel_n_in,
   output logic bus_devsel_n_out,
   input wire logic bus_stop_n_in,
   output logic bus_stop_n_out,
   output logic bus_tgt_oe
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (DEVSEL_TIMEOUT < 4'h2) begin : g_bad_timeout
      $error("DEVSEL_TIMEOUT must be at least two clocks");
   end

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      pcbp_pkg::pcbp_mst_t mst;      // Master sequencer state.
      logic [7:0] lat_cnt;           // Latency timer countdown.
      logic [3:0] dev_cnt;           // Clocks waited for a target claim.
      logic req_n;                   // Bus request, active low.
      logic frame_n;                 // Driven frame level.
      logic frame_oe;                // Frame drive enable.
      logic irdy_n;                  // Driven initiator ready level.
      logic irdy_oe;                 // Initiator ready drive enable.
      logic [3:0] cbe_n;             // Driven command or byte enables.
      logic cbe_oe;                  // Command/byte-enable drive enable.
      logic cmd_wr;                  // Master command is of write class.
      logic xfer_d1;                 // Data moved on the previous clock.
      logic last_ph;                 // Final master data phase in progress.
      logic tabort;                  // Target abort seen.
      logic tto;                     // No target claimed the access.
      logic frame_q;                 // Frame level on the previous clock.
      pcbp_pkg::pcbp_tgt_t tgt;      // Target sequencer state.
      logic [31:0] addr_wdata;       // Address, then write data, to back end.
      logic [3:0] tcbe;              // Command, then byte enables, to back end.
      logic adr_valid;               // First clock of a target access.
      logic adr_inc;                 // Previous target transfer completed.
      logic wr_active;               // Target write in progress.
      logic devsel_n;                // Driven device select level.
      logic trdy_n;                  // Driven target ready level.
      logic stop_n;                  // Driven stop level.
      logic tgt_oe;                  // Target control drive enable.
   } pcbp_state_t;

   pcbp_state_t q_r;    // Registered state.
   pcbp_state_t q_nxt;  // Next state.

   // Data moves on an edge where our ready and the target's ready are both low.
   logic mst_xfer;
   assign mst_xfer = q_r.irdy_oe && !q_r.irdy_n && !bus_trdy_n_in;

   // Latency timer has run out and arbitration wants the bus back.
   logic lat_expired;
   assign lat_expired = latency_counter_enable && (q_r.lat_cnt == 8'h00) && bus_gnt_n;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // One pass computes both sequencers; pulses default low every clock.
   always_comb begin
      q_nxt = q_r;
      q_nxt.xfer_d1 = mst_xfer;
      q_nxt.tabort = 1'b0;
      q_nxt.tto = 1'b0;
      q_nxt.adr_valid = 1'b0;
      q_nxt.adr_inc = 1'b0;
      q_nxt.frame_q = bus_frame_n_in;
      q_nxt.cmd_wr = pcbp_pkg::cmd_is_write(pci_cmd);

      // Master sequencer.
      unique case (q_r.mst)
         pcbp_pkg::MST_IDLE: begin
            // A pending burst drives the request line low.
            if (burst_req) begin
               q_nxt.req_n = 1'b0;
               q_nxt.mst = pcbp_pkg::MST_REQ;
            end
         end
         pcbp_pkg::MST_REQ: begin
            if (!burst_req) begin
               // Request withdrawn before the grant came.
               q_nxt.req_n = 1'b1;
               q_nxt.mst = pcbp_pkg::MST_IDLE;
            end else if (!bus_gnt_n && bus_frame_n_in && bus_irdy_n_in &&
                         q_r.tgt == pcbp_pkg::TGT_IDLE) begin
               // Granted and the bus is idle: address phase with the command.
               q_nxt.req_n = 1'b1;
               q_nxt.frame_n = 1'b0;
               q_nxt.frame_oe = 1'b1;
               q_nxt.cbe_n = pci_cmd;
               q_nxt.cbe_oe = 1'b1;
               q_nxt.lat_cnt = latency_timer;
               q_nxt.dev_cnt = 4'h0;
               q_nxt.mst = pcbp_pkg::MST_ADDR;
            end
         end
         pcbp_pkg::MST_ADDR: begin
            // First data phase; a single-word burst ends frame at once.
            q_nxt.irdy_n = 1'b0;
            q_nxt.irdy_oe = 1'b1;
            q_nxt.cbe_n = pcbp_pkg::BE_ALL_ON_N;
            q_nxt.frame_n = last_transfer_left;
            q_nxt.mst = pcbp_pkg::MST_DATA;
         end
         pcbp_pkg::MST_DATA: begin
            if (q_r.lat_cnt != 8'h00) begin
               q_nxt.lat_cnt = q_r.lat_cnt - 8'h01;
            end
            if (bus_devsel_n_in && q_r.dev_cnt != 4'hf) begin
               q_nxt.dev_cnt = q_r.dev_cnt + 4'h1;
            end
            if (!bus_stop_n_in && bus_devsel_n_in && q_r.dev_cnt < DEVSEL_TIMEOUT) begin
               // Stop without device select: the target aborted us.
               q_nxt.tabort = 1'b1;
               q_nxt.frame_n = 1'b1;
               q_nxt.irdy_n = 1'b1;
               q_nxt.mst = pcbp_pkg::MST_TURN;
            end else if (bus_devsel_n_in && q_r.dev_cnt >= DEVSEL_TIMEOUT - 4'h1) begin
               // Nobody claimed the access; end it as a master abort.
               if (!q_r.frame_n) begin
                  // Frame goes high first; the flag follows as ready is released.
                  q_nxt.frame_n = 1'b1;
               end else begin
                  // Flagging here also reports a single-word access that raised frame early.
                  q_nxt.tto = 1'b1;
                  q_nxt.irdy_n = 1'b1;
                  q_nxt.mst = pcbp_pkg::MST_TURN;
               end
            end else if (q_r.frame_n && (mst_xfer || !bus_stop_n_in)) begin
               // Final phase done or disconnected: release the bus.
               q_nxt.irdy_n = 1'b1;
               q_nxt.mst = pcbp_pkg::MST_TURN;
            end else if (!q_r.frame_n && (last_transfer_left || !bus_stop_n_in ||
                                          lat_expired || !burst_req)) begin
               // Next transfer is the last one, so frame goes high now.
               q_nxt.frame_n = 1'b1;
            end
         end
         pcbp_pkg::MST_TURN: begin
            // Frame and ready were driven high for one clock; now float them and the byte enables.
            q_nxt.frame_oe = 1'b0;
            q_nxt.irdy_oe = 1'b0;
            q_nxt.cbe_oe = 1'b0;
            q_nxt.mst = pcbp_pkg::MST_IDLE;
         end
      endcase

      // Final phase: frame released while our ready is still asserted.
      q_nxt.last_ph = (q_nxt.mst == pcbp_pkg::MST_DATA) && q_nxt.frame_n &&
                      !q_nxt.irdy_n;

      // Target sequencer.
      unique case (q_r.tgt)
         pcbp_pkg::TGT_IDLE: begin
            // A falling frame that we did not start opens a target access.
            if (q_r.frame_q && !bus_frame_n_in && (q_r.mst == pcbp_pkg::MST_IDLE ||
                                                 q_r.mst == pcbp_pkg::MST_REQ)) begin
               q_nxt.addr_wdata = bus_ad_in;
               q_nxt.tcbe = bus_cbe_n_in;
               q_nxt.adr_valid = 1'b1;
               q_nxt.wr_active = pcbp_pkg::cmd_is_write(bus_cbe_n_in);
               q_nxt.tgt = pcbp_pkg::TGT_DECODE;
            end
         end
         pcbp_pkg::TGT_DECODE: begin
            // The back end answered with its decode during the valid clock.
            if (user_select) begin
               q_nxt.devsel_n = 1'b0;
               q_nxt.trdy_n = 1'b0;
               q_nxt.stop_n = 1'b1;
               q_nxt.tgt_oe = 1'b1;
               q_nxt.tgt = pcbp_pkg::TGT_DATA;
            end else begin
               q_nxt.wr_active = 1'b0;
               q_nxt.tgt = pcbp_pkg::TGT_IDLE;
            end
         end
         pcbp_pkg::TGT_DATA: begin
            // Byte enables track the bus through every data phase.
            q_nxt.tcbe = bus_cbe_n_in;
            if (!bus_irdy_n_in) begin
               // Zero-wait target: a transfer completes whenever the master is ready.
               q_nxt.adr_inc = 1'b1;
               if (q_r.wr_active) begin
                  q_nxt.addr_wdata = bus_ad_in;
               end
            end
            if (bus_frame_n_in && (!bus_irdy_n_in || bus_irdy_n_in)) begin
               // Frame high means this clock held the final phase.
               q_nxt.devsel_n = 1'b1;
               q_nxt.trdy_n = 1'b1;
               q_nxt.tgt = pcbp_pkg::TGT_TURN;
            end
         end
         pcbp_pkg::TGT_TURN: begin
            // Control lines were driven high once; float them, end the write.
            q_nxt.tgt_oe = 1'b0;
            q_nxt.wr_active = 1'b0;
            q_nxt.tgt = pcbp_pkg::TGT_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Every output below comes straight from this record.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q_r <= '{mst: pcbp_pkg::MST_IDLE, lat_cnt: 8'h00, dev_cnt: 4'h0, req_n: 1'b1,
                  frame_n: 1'b1, frame_oe: 1'b0, irdy_n: 1'b1, irdy_oe: 1'b0,
                  cbe_n: 4'hf, cbe_oe: 1'b0, cmd_wr: 1'b0, xfer_d1: 1'b0,
                  last_ph: 1'b0, tabort: 1'b0, tto: 1'b0, frame_q: 1'b1,
                  tgt: pcbp_pkg::TGT_IDLE, addr_wdata: 32'h0000_0000, tcbe: 4'hf,
                  adr_valid: 1'b0, adr_inc: 1'b0, wr_active: 1'b0, devsel_n: 1'b1,
                  trdy_n: 1'b1, stop_n: 1'b1, tgt_oe: 1'b0};
      end else begin
         q_r <= q_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The copies share the flip-flops that drive the pins.
   assign master_cmd_is_write = q_r.cmd_wr;
   assign transfer_delayed_strobe = q_r.xfer_d1;
   assign master_last_phase = q_r.last_ph;
   assign bus_request_copy_n = q_r.req_n;
   assign initiator_ready_copy_n = q_r.irdy_n;
   assign target_abort_flag = q_r.tabort;
   assign target_timeout_flag = q_r.tto;
   assign target_addr_wdata = q_r.addr_wdata;
   assign target_cmd_byte_en = q_r.tcbe;
   assign address_valid = q_r.adr_valid;
   assign address_increment = q_r.adr_inc;
   assign target_write_active = q_r.wr_active;
   assign bus_req_n = q_r.req_n;
   assign bus_cbe_n_out = q_r.cbe_n;
   assign bus_cbe_oe = q_r.cbe_oe;
   assign bus_frame_n_out = q_r.frame_n;
   assign bus_frame_oe = q_r.frame_oe;
   assign bus_irdy_n_out = q_r.irdy_n;
   assign bus_irdy_oe = q_r.irdy_oe;
   assign bus_trdy_n_out = q_r.trdy_n;
   assign bus_devsel_n_out = q_r.devsel_n;
   assign bus_stop_n_out = q_r.stop_n;
   assign bus_tgt_oe = q_r.tgt_oe;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // A memory write command shows as write one clock later.
   cmd_class_a: assert property ((pci_cmd == pcbp_pkg::CMD_MEM_WR) |=> master_cmd_is_write)
      else $error("write command not classed as write");
   // Ignored latency timer never ends a healthy burst early.
   lat_ignore_a: assert property ((q_r.mst == pcbp_pkg::MST_DATA && !q_r.frame_n &&
      !latency_counter_enable && !last_transfer_left && burst_req && bus_stop_n_in &&
      !bus_devsel_n_in) |=> !bus_frame_n_out)
      else $error("latency timer ended burst while disabled");
   // Each moved word yields exactly one strobe in the next clock.
   xfer_strobe_a: assert property (mst_xfer |=> transfer_delayed_strobe)
      else $error("transfer strobe missing after data moved");
   // Final-phase flag only with frame high and ready low.
   last_phase_a: assert property (master_last_phase |-> bus_frame_n_out &&
      !bus_irdy_n_out && bus_irdy_oe)
      else $error("last phase flag without final phase");
   // Request copy low only while waiting for the grant.
   req_copy_a: assert property (!bus_request_copy_n |-> q_r.mst == pcbp_pkg::MST_REQ)
      else $error("request copy low outside request state");
   // Stop without claim during data gives the abort flag.
   tabort_a: assert property ((q_r.mst == pcbp_pkg::MST_DATA && !bus_stop_n_in &&
      bus_devsel_n_in && q_r.dev_cnt < DEVSEL_TIMEOUT) |=> target_abort_flag)
      else $error("target abort not flagged");
   // Timeout flag only after the full wait without a claim.
   timeout_a: assert property (target_timeout_flag |-> $past(q_r.dev_cnt) >=
      DEVSEL_TIMEOUT - 4'h1 && bus_frame_n_out)
      else $error("timeout flagged too early");
   // Address and command appear with the valid strobe.
   addr_out_a: assert property (address_valid |-> target_addr_wdata == $past(bus_ad_in) &&
      target_cmd_byte_en == $past(bus_cbe_n_in))
      else $error("address or command not shown with valid");
   // Write data follows each target write transfer.
   wdata_a: assert property ((q_r.tgt == pcbp_pkg::TGT_DATA && q_r.wr_active &&
      !bus_irdy_n_in) |=> target_addr_wdata == $past(bus_ad_in))
      else $error("write data not presented");
   // Byte enables follow the bus during data phases.
   byte_en_a: assert property ((q_r.tgt == pcbp_pkg::TGT_DATA) |=>
      target_cmd_byte_en == $past(bus_cbe_n_in))
      else $error("byte enables not presented");
   // Valid strobe lasts one clock and stays low for the next three clocks.
   valid_once_a: assert property (address_valid |=> !address_valid [*3])
      else $error("address valid repeated");
   // Each completed target transfer yields an increment.
   inc_a: assert property ((q_r.tgt == pcbp_pkg::TGT_DATA && !bus_irdy_n_in) |=>
      address_increment)
      else $error("address increment missing");
   // Write-active falls only as the access closes.
   wr_hold_a: assert property ($fell(target_write_active) |->
      $past(q_r.tgt) inside {pcbp_pkg::TGT_TURN, pcbp_pkg::TGT_DECODE})
      else $error("write active dropped mid write");

   master_burst_c: cover property (master_last_phase ##1 transfer_delayed_strobe);
   target_write_c: cover property (address_valid && target_write_active ##3 address_increment);
   abort_c: cover property (target_abort_flag);
   timeout_c: cover property (target_timeout_flag);

endmodule : pcbp_core

// >>> inc/pcbp_pkg.sv
// Purpose: Shared constants, state types and command helpers of the back-end port.
// Assumes: One bus clock; every bus pin and back-end signal is synchronous to it.
// Notes:   Command codes follow the standard parallel-bus command encoding.
package pcbp_pkg;

   // ----------------------------------------------------------------
   // Widths and fixed values
   // ----------------------------------------------------------------
   localparam int ADDR_W = 32;                 // Address and data path width.
   localparam int CBE_W = 4;                   // Command and byte-enable width.
   localparam int LAT_W = 8;                   // Latency timer width.
   localparam logic [3:0] BE_ALL_ON_N = 4'h0;  // All byte lanes on, active low.
   localparam logic [3:0] DEVSEL_LIMIT = 4'h5; // Clocks without a target claim.

   // ----------------------------------------------------------------
   // Bus command encodings
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_INT_ACK = 4'h0;
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;
   localparam logic [3:0] CMD_MEM_RD_MUL = 4'hc;
   localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
   localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {MST_IDLE, MST_REQ, MST_ADDR, MST_DATA, MST_TURN} pcbp_mst_t;
   typedef enum logic [1:0] {TGT_IDLE, TGT_DECODE, TGT_DATA, TGT_TURN} pcbp_tgt_t;

   // True for the write class of commands; read-class and reserved codes give false.
   function automatic logic cmd_is_write(input logic [3:0] cmd);
      cmd_is_write = (cmd == CMD_SPECIAL) || (cmd == CMD_IO_WR) || (cmd == CMD_MEM_WR) ||
                     (cmd == CMD_CFG_WR) || (cmd == CMD_MEM_WR_INV);
   endfunction : cmd_is_write

endpackage : pcbp_pkg

// >>> tb/pcbp_decode_model.sv
// Purpose: Back-end decode model that faces the target side of the port.
// Assumes: Our space is every address whose top nibble equals HIT.
// Notes:   Keeps its own burst address, stepped by one word per transfer.
module pcbp_decode_model #(
   parameter logic [3:0] HIT = 4'h8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic address_valid,
   input wire logic address_increment,
   input wire logic [31:0] target_addr_wdata,
   output logic user_select,
   output logic [31:0] burst_addr_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // Claim only while the address is shown; later clocks carry data.
   assign user_select = address_valid && (target_addr_wdata[31:28] == HIT);
   // Latch the start address, then add a word per transfer.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         burst_addr_r <= 32'h0;
      end else if (address_valid) begin
         burst_addr_r <= target_addr_wdata;
      end else if (address_increment) begin
         burst_addr_r <= burst_addr_r + 32'h4;
      end
   end
endmodule : pcbp_decode_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench; it plays the DMA side and the far bus agent.
// Assumes: Pull-ups on all shared lines; bench drives a line only when the core does not.
// Notes:   Event counts replace cycle-exact checks where the latency is the core's choice.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_b = 1'b0, burst_req = 1'b0, latency_counter_enable = 1'b1;
   logic last_transfer_left = 1'b1, bus_gnt_n = 1'b1, tb_frame_n = 1'b1, tb_irdy_n = 1'b1;
   logic tb_trdy_n = 1'b1, tb_devsel_n = 1'b1, tb_stop_n = 1'b1;
   logic [3:0] pci_cmd = 4'h0, tb_cbe = 4'hf, target_cmd_byte_en, bus_cbe_n_out;
   logic [7:0] latency_timer = 8'h0;
   logic [31:0] bus_ad_in = 32'h0, target_addr_wdata, burst_addr_r;
   logic master_cmd_is_write, transfer_delayed_strobe, master_last_phase, bus_request_copy_n;
   logic initiator_ready_copy_n, target_abort_flag, target_timeout_flag, user_select;
   logic address_valid, address_increment, target_write_active, bus_req_n, bus_cbe_oe;
   logic bus_frame_n_out, bus_frame_oe, bus_irdy_n_out, bus_irdy_oe, bus_trdy_n_out;
   logic bus_devsel_n_out, bus_stop_n_out, bus_tgt_oe;
   // Each shared line shows the core's drive when enabled, else the far agent's.
   wire logic [3:0] bus_cbe_n_in = bus_cbe_oe ? bus_cbe_n_out : tb_cbe;
   wire logic bus_frame_n_in = bus_frame_oe ? bus_frame_n_out : tb_frame_n;
   wire logic bus_irdy_n_in = bus_irdy_oe ? bus_irdy_n_out : tb_irdy_n;
   wire logic bus_trdy_n_in = bus_tgt_oe ? bus_trdy_n_out : tb_trdy_n;
   wire logic bus_devsel_n_in = bus_tgt_oe ? bus_devsel_n_out : tb_devsel_n;
   wire logic bus_stop_n_in = bus_tgt_oe ? bus_stop_n_out : tb_stop_n;
   // Event vector; cnt[k] counts clocks with ev[k] high since the last clear.
   wire logic [10:0] ev = {!initiator_ready_copy_n, bus_irdy_oe && !bus_irdy_n_out,
      !bus_request_copy_n, !bus_req_n, bus_tgt_oe, address_valid, address_increment,
      target_abort_flag, target_timeout_flag, master_last_phase, transfer_delayed_strobe};
   int cnt [11];
   int bad_count = 0;
   int num_checks = 0;
   // Command table: bit 4 marks the write class.
   logic [4:0] tab [11] = '{5'h00, 5'h11, 5'h02, 5'h13, 5'h06, 5'h17, 5'h0a, 5'h1b, 5'h0c,
      5'h0e, 5'h1f};
   pcbp_core pcbp_core_inst (
      .core_clk, .rst_b, .burst_req, .pci_cmd, .latency_counter_enable, .latency_timer,
      .last_transfer_left, .master_cmd_is_write, .transfer_delayed_strobe, .master_last_phase,
      .bus_request_copy_n, .initiator_ready_copy_n, .target_abort_flag, .target_timeout_flag,
      .user_select, .target_addr_wdata, .target_cmd_byte_en, .address_valid,
      .address_increment, .target_write_active, .bus_gnt_n, .bus_req_n, .bus_ad_in,
      .bus_cbe_n_in, .bus_cbe_n_out, .bus_cbe_oe, .bus_frame_n_in, .bus_frame_n_out,
      .bus_frame_oe, .bus_irdy_n_in, .bus_irdy_n_out, .bus_irdy_oe, .bus_trdy_n_in,
      .bus_trdy_n_out, .bus_devsel_n_in, .bus_devsel_n_out, .bus_stop_n_in, .bus_stop_n_out,
      .bus_tgt_oe);
   pcbp_decode_model pcbp_decode_model_inst (.core_clk, .rst_b, .address_valid,
      .address_increment, .target_addr_wdata, .user_select, .burst_addr_r);
   always #4 core_clk = ~core_clk;
   // Sampled on rising edges only, like the core itself.
   always @(posedge core_clk) begin
      foreach (cnt[k]) cnt[k] += int'(ev[k]);
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (exp !== got) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   // Mode 0: nobody claims; 1: zero-wait claim; 2: stop without a claim.
   // More than one word runs a burst with the latency timer disabled and expired.
   task automatic master(input logic [4:0] e, input int mode, input int words);
      cnt = '{default: 0};
      @(posedge core_clk);
      burst_req <= 1'b1;
      pci_cmd <= e[3:0];
      latency_timer <= (words > 1) ? 8'h00 : 8'($urandom);
      latency_counter_enable <= (words == 1);
      last_transfer_left <= (words == 1);
      bus_gnt_n <= 1'b0;
      tb_trdy_n <= (mode != 1);
      tb_devsel_n <= (mode != 1);
      tb_stop_n <= (mode != 2);
      for (int i = 0; i < 20 && !(bus_frame_oe && !bus_frame_n_out); i++) begin
         @(posedge core_clk);
         #1;
      end
      chk("master cmd", e[3:0], bus_cbe_n_out);
      chk("write class", e[4], master_cmd_is_write);
      repeat (words - 1) begin
         @(posedge core_clk);
         bus_gnt_n <= 1'b1;
      end
      last_transfer_left <= 1'b1;
      for (int i = 0; i < 20 && !master_last_phase && !target_timeout_flag && !target_abort_flag; i++) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      burst_req <= 1'b0;
      bus_gnt_n <= 1'b1;
      latency_counter_enable <= 1'b1;
      {tb_trdy_n, tb_devsel_n, tb_stop_n} <= 3'h7;
      repeat (12) @(posedge core_clk);
      #1;
      chk("xfer strobes", (mode == 1) ? words : 0, cnt[0]);
      if (mode == 1) chk("last phase", 1, cnt[1]);
      chk("timeout", mode == 0, cnt[2]);
      chk("abort", mode == 2, cnt[3]);
      chk("req copy", cnt[7], cnt[8]);
      chk("irdy copy", cnt[9], cnt[10]);
   endtask : master
   task automatic target(input logic wr, input logic [31:0] a, input logic [31:0] d,
         input logic [3:0] be);
      logic [3:0] c;
      logic sel;
      c = wr ? pcbp_pkg::CMD_MEM_WR : pcbp_pkg::CMD_MEM_RD;
      sel = (a[31:28] == 4'h8);
      cnt = '{default: 0};
      @(posedge core_clk);
      {tb_frame_n, bus_ad_in, tb_cbe} <= {1'b0, a, c};
      @(posedge core_clk);
      {bus_ad_in, tb_cbe} <= {d, be};
      #1;
      chk("address", a, target_addr_wdata);
      chk("command", c, target_cmd_byte_en);
      chk("addr valid", 1, address_valid);
      chk("write active", wr, target_write_active);
      for (int i = 0; i < 6 && !(bus_tgt_oe && !bus_trdy_n_out); i++) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      {tb_irdy_n, tb_frame_n} <= 2'h1;
      @(posedge core_clk);
      tb_irdy_n <= 1'b1;
      #1;
      if (sel) chk("byte enables", be, target_cmd_byte_en);
      if (sel && wr) chk("write data", d, target_addr_wdata);
      if (sel) chk("write held", wr, target_write_active);
      chk("increment", sel, address_increment);
      repeat (4) @(posedge core_clk);
      #1;
      if (sel) chk("model addr", a + 32'h4, burst_addr_r);
      chk("claimed", sel, cnt[6] > 0);
      chk("valid pulses", 1, cnt[5]);
      chk("write ended", 0, target_write_active);
   endtask : target
   initial begin
      #40000;
      bad_count++;
      complete_run();
   end
   initial begin
      void'($urandom(23500));
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      chk("reset req", 1, bus_req_n);
      chk("reset be", 4'hf, target_cmd_byte_en);
      foreach (tab[k]) master(tab[k], 1, 1);
      master(tab[$urandom_range(10)], 0, 1);
      master(tab[$urandom_range(10)], 2, 1);
      master(tab[$urandom_range(10)], 1, 3 + $urandom_range(5));
      for (int k = 0; k < 4; k++) target(k[0], {k[1] ? 4'h8 : 4'h3, 28'($urandom)}, $urandom,
         4'($urandom));
      complete_run();
   end
endmodule : tb_top
